/* hw/prs_device.sv */
// Purpose: Device end: bus-ready timer, main-map bits and indirect paged PLL reset controls.
// Assumes: Power-down pin synchronous to clk; writes come one per cycle at most.
// Notes: Writes before bus_ready are dropped; only modelled registers are stored.
module prs_device #(
  parameter int READY_CYCLES = prs_pkg::READY_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic reset,
  // Link
  prs_link_if.device link,
  // Control outputs
  output logic video_pll_fsm_reset,
  output logic link_pll_fsm_reset,
  output logic link_freq_auto_reset,
  output logic blank_video_block,
  output logic [7:0] bus_filter
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [prs_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic [7:0] page_reg, page_next;
  logic [7:0] ofs_reg, ofs_next;
  logic [7:0] vctl_reg, vctl_next;
  logic [7:0] lctl_reg, lctl_next;
  logic [7:0] freq_reg, freq_next;
  logic [7:0] blank_reg, blank_next;
  logic [7:0] filt_reg, filt_next;
  logic wr;

  assign wr = link.bus_wr && ready_reg;

  always_comb begin
    cnt_next = cnt_reg;
    ready_next = ready_reg;
    page_next = page_reg;
    ofs_next = ofs_reg;
    vctl_next = vctl_reg;
    lctl_next = lctl_reg;
    freq_next = freq_reg;
    blank_next = blank_reg;
    filt_next = filt_reg;
    if (!link.power_down_bar_pin) begin
      cnt_next = '0;
      ready_next = 1'b0;
    end else if (!ready_reg) begin
      if (cnt_reg == prs_pkg::CNT_W'(READY_CYCLES - 1)) begin
        ready_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
    if (wr) begin
      unique case (link.bus_addr)
        prs_pkg::ADDR_PAGE_SEL: page_next = link.bus_wdata;
        prs_pkg::ADDR_PAGE_OFS: ofs_next = link.bus_wdata;
        prs_pkg::ADDR_FREQ_CTL: freq_next = link.bus_wdata;
        prs_pkg::ADDR_BLANK_CTL: blank_next = link.bus_wdata;
        prs_pkg::ADDR_BUS_FILTER: filt_next = link.bus_wdata;
        prs_pkg::ADDR_PAGE_DATA: begin
          if (ofs_reg == prs_pkg::OFS_PLL_CTL && page_reg == prs_pkg::PAGE_VIDEO) begin
            vctl_next = link.bus_wdata & prs_pkg::PLL_CTL_MASK;
          end
          if (ofs_reg == prs_pkg::OFS_PLL_CTL && page_reg == prs_pkg::PAGE_LINK) begin
            lctl_next = link.bus_wdata & prs_pkg::PLL_CTL_MASK;
          end
        end
        default: ;
      endcase
    end
  end

  // Power-down pin low returns everything to defaults, as a hard reset would.
  always_ff @(posedge clk) begin
    if (reset || !link.power_down_bar_pin) begin
      cnt_reg <= '0;
      ready_reg <= 1'b0;
      page_reg <= 8'h00;
      ofs_reg <= 8'h00;
      vctl_reg <= prs_pkg::PLL_CTL_RESET;
      lctl_reg <= prs_pkg::PLL_CTL_RESET;
      freq_reg <= prs_pkg::FREQ_RESET;
      blank_reg <= prs_pkg::BLANK_RESET;
      filt_reg <= prs_pkg::FILTER_RESET;
    end else begin
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
      page_reg <= page_next;
      ofs_reg <= ofs_next;
      vctl_reg <= vctl_next;
      lctl_reg <= lctl_next;
      freq_reg <= freq_next;
      blank_reg <= blank_next;
      filt_reg <= filt_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // video PLL hold
  assign video_pll_fsm_reset = vctl_reg[prs_pkg::PLL_RST_BIT];
  assign link_pll_fsm_reset = lctl_reg[prs_pkg::PLL_RST_BIT];
  assign link_freq_auto_reset = freq_reg[prs_pkg::FREQ_RST_BIT];
  assign blank_video_block = blank_reg[prs_pkg::BLANK_BIT];
  assign bus_filter = filt_reg;
  assign link.bus_ready = ready_reg;

endmodule

/* hw/prs_host.sv */
// Purpose: Host end: drives power-down pin and writes sequences A and B.
// Assumes: Software sets power and start bits; clock stability is an input level.
// Notes: Sequence B waits for the stable level to hold for the stable count.
//
// Our own choice: strobed register access.
module prs_host #(
  parameter int READY_CYCLES = prs_pkg::READY_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic reset,
  // Link
  prs_link_if.host link,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Status from board
  input wire logic supplies_ok,
  input wire logic in_clk_stable
);

  typedef enum logic [5:0] {
    ST_OFF = 6'h01, ST_WAIT = 6'h02, ST_SEQA = 6'h04, ST_CLK = 6'h08, ST_SEQB = 6'h10, ST_DONE = 6'h20
  } prs_state_e;

  // ----------------------------------------------------------------
  // Write script
  // ----------------------------------------------------------------
  localparam int NA = 3;
  localparam int NB = 8;
  function automatic logic [15:0] step(input logic [3:0] i);
    logic [15:0] r;
    r = {prs_pkg::ADDR_PAGE_DATA, prs_pkg::PLL_RST_OFF};
    unique case (i)
      4'h0: r = {prs_pkg::ADDR_FREQ_CTL, 8'h00};
      4'h1: r = {prs_pkg::ADDR_BUS_FILTER, prs_pkg::BUS_FILTER_VAL};
      4'h2: r = {prs_pkg::ADDR_BLANK_CTL, 8'h01 << prs_pkg::BLANK_BIT};
      4'h3: r = {prs_pkg::ADDR_PAGE_SEL, prs_pkg::PAGE_VIDEO};
      4'h4: r = {prs_pkg::ADDR_PAGE_OFS, prs_pkg::OFS_PLL_CTL};
      4'h5: r = {prs_pkg::ADDR_PAGE_DATA, prs_pkg::PLL_RST_ON};
      4'h6: r = {prs_pkg::ADDR_PAGE_DATA, prs_pkg::PLL_RST_OFF};
      4'h7: r = {prs_pkg::ADDR_PAGE_SEL, prs_pkg::PAGE_LINK};
      4'h8: r = {prs_pkg::ADDR_PAGE_OFS, prs_pkg::OFS_PLL_CTL};
      4'h9: r = {prs_pkg::ADDR_PAGE_DATA, prs_pkg::PLL_RST_ON};
      default: r = {prs_pkg::ADDR_PAGE_DATA, prs_pkg::PLL_RST_OFF};
    endcase
    return r;
  endfunction

  prs_state_e st_reg, st_next;
  logic [prs_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [3:0] idx_reg, idx_next;
  logic pwr_reg, pwr_next, start_reg, start_next;
  logic pin_reg, pin_next, wr_reg, wr_next;
  logic [7:0] addr_reg, addr_next, data_reg, data_next, rd_reg, rd_next;
  logic [15:0] cur;

  assign cur = step(idx_reg);

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    pwr_next = pwr_reg;
    start_next = start_reg;
    pin_next = pin_reg;
    wr_next = 1'b0;
    addr_next = addr_reg;
    data_next = data_reg;
    rd_next = 8'h00;
    if (reg_wr && reg_addr == prs_pkg::HREG_CTRL) begin
      pwr_next = reg_wdata[prs_pkg::HCTRL_PWR];
      start_next = reg_wdata[prs_pkg::HCTRL_START];
    end
    if (reg_rd && reg_addr == prs_pkg::HREG_STATUS) begin
      rd_next = {2'b00, st_reg};
    end else if (reg_rd && reg_addr == prs_pkg::HREG_CTRL) begin
      rd_next = {6'h00, pwr_reg, start_reg};
    end
    unique case (st_reg)
      ST_OFF: begin
        cnt_next = '0;
        idx_next = '0;
        if (pwr_reg && supplies_ok) begin
          pin_next = 1'b1;
          st_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_reg == prs_pkg::CNT_W'(READY_CYCLES - 1)) begin
          st_next = ST_SEQA;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_SEQA: begin
        wr_next = 1'b1;
        addr_next = cur[15:8];
        data_next = cur[7:0];
        idx_next = idx_reg + 1'b1;
        if (idx_reg == 4'(NA - 1)) begin
          cnt_next = '0;
          st_next = ST_CLK;
        end
      end
      ST_CLK: begin
        if (!in_clk_stable) begin
          cnt_next = '0;
        end else if (cnt_reg == prs_pkg::CNT_W'(prs_pkg::STABLE_CYCLES - 1)) begin
          if (start_reg) begin
            st_next = ST_SEQB;
          end
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_SEQB: begin
        wr_next = 1'b1;
        addr_next = cur[15:8];
        data_next = cur[7:0];
        idx_next = idx_reg + 1'b1;
        if (idx_reg == 4'(NA + NB - 1)) begin
          st_next = ST_DONE;
        end
      end
      ST_DONE: begin
        start_next = 1'b0;
      end
    endcase
    if (!pwr_reg) begin
      // A write must never reach the device while the pin is low.
      pin_next = 1'b0;
      wr_next = 1'b0;
      st_next = ST_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= ST_OFF;
      cnt_reg <= '0;
      idx_reg <= '0;
      pwr_reg <= 1'b0;
      start_reg <= 1'b0;
      pin_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
      rd_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      pwr_reg <= pwr_next;
      start_reg <= start_next;
      pin_reg <= pin_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      rd_reg <= rd_next;
    end
  end

  assign link.power_down_bar_pin = pin_reg;
  assign link.bus_wr = wr_reg;
  assign link.bus_addr = addr_reg;
  assign link.bus_wdata = data_reg;
  assign reg_rdata = rd_reg;

endmodule

/* include/prs_link_if.sv */
// Purpose: Carrier between host controller and device control logic.
// Assumes: One clock; host is the sole master of the control bus.
// Notes: Bus writes are single-cycle strobes, no wait states.
interface prs_link_if;
  logic power_down_bar_pin;
  logic bus_wr;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_ready;

  modport device (
    input power_down_bar_pin,
    input bus_wr,
    input bus_addr,
    input bus_wdata,
    output bus_ready
  );

  modport host (
    output power_down_bar_pin,
    output bus_wr,
    output bus_addr,
    output bus_wdata,
    input bus_ready
  );
endinterface

/* include/prs_pkg.sv */
// Purpose: Constants shared by the power-up sequencer ends (device and host controller).
// Assumes: 25 MHz clock, synchronous active-high reset.
// Notes: Main-map and paged offsets, sequence values and wait counts live here.
package prs_pkg;

  // ----------------------------------------------------------------
  // Main-map offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BLANK_CTL = 8'h04;
  localparam logic [7:0] ADDR_BUS_FILTER = 8'h16;
  localparam logic [7:0] ADDR_PAGE_SEL = 8'h40;
  localparam logic [7:0] ADDR_PAGE_OFS = 8'h41;
  localparam logic [7:0] ADDR_PAGE_DATA = 8'h42;
  localparam logic [7:0] ADDR_FREQ_CTL = 8'h5b;

  // ----------------------------------------------------------------
  // Paged registers and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_VIDEO = 8'h10;
  localparam logic [7:0] PAGE_LINK = 8'h14;
  localparam logic [7:0] OFS_PLL_CTL = 8'h49;
  localparam int PLL_RST_BIT = 4;
  localparam int BLANK_BIT = 4;
  localparam int FREQ_RST_BIT = 5;
  localparam logic [7:0] PLL_RST_ON = 8'h10;
  localparam logic [7:0] PLL_RST_OFF = 8'h00;
  localparam logic [7:0] PLL_CTL_MASK = 8'h10;
  localparam logic [7:0] PLL_CTL_RESET = 8'h00;
  localparam logic [7:0] BUS_FILTER_VAL = 8'h02;
  localparam logic [7:0] BLANK_RESET = 8'h00;
  localparam logic [7:0] FREQ_RESET = 8'h20;
  localparam logic [7:0] FILTER_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int READY_TIME_MS = 2;
  localparam int READY_CYCLES = CLK_HZ / 1000 * READY_TIME_MS;
  localparam int STABLE_TIME_US = 1;
  localparam int STABLE_CYCLES = (CLK_HZ / 1000000 * STABLE_TIME_US > 0) ? CLK_HZ / 1000000 * STABLE_TIME_US : 1;
  localparam int CNT_W = 20;

  // ----------------------------------------------------------------
  // Host register map (host command port)
  // ----------------------------------------------------------------
  localparam logic [3:0] HREG_CTRL = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h1;
  localparam int HCTRL_START = 0;
  localparam int HCTRL_PWR = 1;

endpackage

/* tb/pll_reset_init_sequencer_test.sv */
// Purpose: Self-checking bench joining host and device ends.
// Assumes: Ready count shortened to 20 cycles on both ends.
// Notes: Clock stability is held off at random to catch early B writes.
module pll_reset_init_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RC = 20;
  logic clk = 0;
  logic reset = 1;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic supplies_ok = 0;
  logic in_clk_stable = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic vr, lr, fr, bb;
  logic [7:0] bf;
  logic [7:0] st;
  logic [15:0] seen[$];
  logic saw_v = 0;
  logic saw_l = 0;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 32'h0667;
  int i;
  int t;
  always #20 clk = ~clk;
  prs_link_if link ();
  prs_device #(.READY_CYCLES(RC)) prs_device_inst (.clk(clk), .reset(reset), .link(link),
    .video_pll_fsm_reset(vr), .link_pll_fsm_reset(lr), .link_freq_auto_reset(fr),
    .blank_video_block(bb), .bus_filter(bf));
  prs_host #(.READY_CYCLES(RC)) prs_host_inst (.clk(clk), .reset(reset), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supplies_ok(supplies_ok), .in_clk_stable(in_clk_stable));
  prs_checker_sva #(.READY_CYCLES(RC)) prs_checker_sva_inst (.clk(clk), .reset(reset),
    .power_down_bar_pin(link.power_down_bar_pin), .bus_wr(link.bus_wr), .bus_addr(link.bus_addr),
    .bus_wdata(link.bus_wdata), .bus_ready(link.bus_ready));
  // ------------------------------------------------------------
  // Monitor of accepted link writes
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (link.bus_wr === 1'b1 && link.bus_ready === 1'b1) seen.push_back({link.bus_addr, link.bus_wdata});
    if (vr === 1'b1 && lr === 1'b0) saw_v <= 1'b1;
    if (lr === 1'b1 && vr === 1'b0 && saw_v) saw_l <= 1'b1;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] exp_wr(int n);
    logic [15:0] tbl [11] = '{16'h5b00, 16'h1602, 16'h0410, 16'h4010, 16'h4149, 16'h4210, 16'h4200,
      16'h4014, 16'h4149, 16'h4210, 16'h4200};
    return tbl[n];
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    #(40 * 20000);
    n_fail++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    supplies_ok <= 1'b1;
    @(posedge clk);
    #1 chk("reset outputs", 16'h2000, {vr, lr, fr, bb, 4'h0, bf});
    wr(4'h2 + 4'(($random(seed) & 32'h7fff) % 14), 8'($random(seed)));
    rd(4'h7, st);
    chk("unmapped read", 16'h0000, {8'h00, st});
    for (t = 0; t < 2; t++) begin
      seen.delete();
      saw_v <= 1'b0;
      saw_l <= 1'b0;
      wr(4'h0, 8'h02);
      repeat (RC + 12 + ($random(seed) & 32'h1f)) @(posedge clk);
      rd(4'h1, st);
      chk("status waiting clock", 16'h0008, {8'h00, st});
      chk("writes before B", 16'd3, 16'(seen.size()));
      chk("outputs after A", 16'h1002, {vr, lr, fr, bb, 4'h0, bf});
      in_clk_stable <= 1'b1;
      wr(4'h0, 8'h03);
      st = 8'h00;
      for (i = 0; i < 100 && st !== 8'h20; i++) rd(4'h1, st);
      chk("status done", 16'h0020, {8'h00, st});
      rd(4'h0, st);
      chk("ctrl readback", 16'h0002, {8'h00, st});
      chk("write count", 16'd11, 16'(seen.size()));
      for (i = 0; i < 11 && i < seen.size(); i++) chk("link write", exp_wr(i), seen[i]);
      chk("pll holds seen", 16'h0003, {14'h0, saw_v, saw_l});
      chk("outputs after B", 16'h1002, {vr, lr, fr, bb, 4'h0, bf});
      wr(4'h0, 8'h00);
      in_clk_stable <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("power off", 16'h2000, {link.power_down_bar_pin, lr, fr, bb, 4'h0, bf});
      rd(4'h1, st);
      chk("status off", 16'h0001, {8'h00, st});
      $display("test %0d done", t);
    end
    results();
  end
endmodule

/* tb/prs_checker_sva.sv */
// Purpose: Checker on the link between host and device ends.
// Assumes: One clock, synchronous active-high reset.
// Notes: Ready bound allows one cycle of slack for the pin register.
module prs_checker_sva #(
  parameter int READY_CYCLES = prs_pkg::READY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link
  input wire logic power_down_bar_pin,
  input wire logic bus_wr,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // Pin-high cycle counter
  // ------------------------------------------------------------
  int up_reg;
  int up_next;
  always_comb begin
    up_next = up_reg;
    if (!power_down_bar_pin) up_next = 0;
    else if (up_reg < READY_CYCLES + 4) up_next = up_reg + 1;
  end
  always_ff @(posedge clk) begin
    if (reset) up_reg <= 0;
    else up_reg <= up_next;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_ready_late;
    bus_ready |-> up_reg >= READY_CYCLES - 1;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("bus ready too early");
  property p_ready_due;
    power_down_bar_pin && up_reg == READY_CYCLES + 2 |-> bus_ready;
  endproperty
  a_ready_due: assert property (p_ready_due) else $error("bus ready missing");
  property p_pin_low;
    !power_down_bar_pin |=> !bus_ready;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("ready while pin low");
  property p_wr_ready;
    bus_wr |-> bus_ready;
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write before ready");
  property p_video_rst;
    bus_wr && bus_addr == 8'h40 && bus_wdata == 8'h10 |=> bus_wr && bus_addr == 8'h41 && bus_wdata == 8'h49
      ##1 bus_wr && bus_addr == 8'h42 && bus_wdata == 8'h10 ##1 bus_wr && bus_addr == 8'h42 && bus_wdata == 8'h00;
  endproperty
  a_video_rst: assert property (p_video_rst) else $error("video reset writes");
  property p_link_rst;
    bus_wr && bus_addr == 8'h40 && bus_wdata == 8'h14 |=> bus_wr && bus_addr == 8'h41 && bus_wdata == 8'h49
      ##1 bus_wr && bus_addr == 8'h42 && bus_wdata == 8'h10 ##1 bus_wr && bus_addr == 8'h42 && bus_wdata == 8'h00;
  endproperty
  a_link_rst: assert property (p_link_rst) else $error("link reset writes");
  property p_b_order;
    bus_wr && bus_addr == 8'h40 && bus_wdata == 8'h10 |-> ##4 bus_wr && bus_addr == 8'h40 && bus_wdata == 8'h14;
  endproperty
  a_b_order: assert property (p_b_order) else $error("video before link");
  property p_reserved;
    bus_wr && bus_addr == 8'h42 |-> bus_wdata[3:0] == 4'h0 && bus_wdata[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  property p_seq_a;
    bus_wr && bus_addr == 8'h5b |-> !bus_wdata[5] ##1 bus_wr && bus_addr == 8'h16 && bus_wdata == 8'h02
      ##1 bus_wr && bus_addr == 8'h04 && bus_wdata[4];
  endproperty
  a_seq_a: assert property (p_seq_a) else $error("sequence A writes");
endmodule
